// ==== logic/sdc_pkg.sv ====
package sdc_pkg;
  // Serial word and register select.
  localparam int WORD_W = 32;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_R0 = 3'h0;
  localparam logic [2:0] SEL_R1 = 3'h1;
  localparam logic [2:0] SEL_R2 = 3'h2;
  localparam logic [2:0] SEL_R3 = 3'h3;
  // Divide word fields.
  localparam int NUM_LSB = 3;
  localparam int NUM_W = 12;
  localparam int INT_LSB = 15;
  localparam int INT_W = 16;
  // Denominator and phase word fields.
  localparam int DEN_LSB = 3;
  localparam int DEN_W = 12;
  localparam int PH_LSB = 15;
  localparam int PH_W = 12;
  localparam int PRE_BIT = 27;
  // Loop configuration word fields.
  localparam int NOISE_LSB = 29;
  localparam int NOISE_W = 2;
  localparam int MON_LSB = 26;
  localparam int MON_W = 3;
  localparam int DBL_BIT = 25;
  // Clock divider word fields.
  localparam int CDV_LSB = 3;
  localparam int CDV_W = 12;
  localparam int CDM_LSB = 15;
  localparam int CDM_W = 2;
  localparam int CSR_BIT = 18;
  // Limits and encodings.
  localparam logic [15:0] INT_MIN_P45 = 16'h0017;
  localparam logic [15:0] INT_MIN_P89 = 16'h004B;
  localparam logic [1:0] NOISE_LOW_NOISE = 2'h0;
  localparam logic [1:0] NOISE_LOW_SPUR = 2'h3;
  localparam logic [2:0] MON_LOW = 3'h0;
  localparam logic [2:0] MON_HIGH = 3'h1;
  localparam logic [2:0] MON_REF = 3'h3;
  localparam logic [2:0] MON_LOAD = 3'h4;
  localparam logic [2:0] MON_DITHER = 3'h5;
  localparam logic [2:0] MON_ERR = 3'h6;
  // Reset values.
  localparam logic [11:0] RST_PHASE = 12'h001;
  localparam logic [11:0] RST_DEN = 12'h002;

  typedef struct packed {
    logic [15:0] int_val;
    logic [11:0] channel_numerator;
  } sdc_div_t;

  typedef struct packed {
    logic prescaler_choice;
    logic [11:0] phase;
    logic [11:0] fraction_denominator;
  } sdc_r1_t;

  typedef struct packed {
    logic [1:0] noise_mode;
    logic [2:0] monitor_pin_select;
    logic ref_doubler;
  } sdc_r2_t;

  typedef struct packed {
    logic csr_en;
    logic [1:0] clkdiv_mode;
    logic [11:0] clkdiv_val;
  } sdc_r3_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } sdc_word_t;
endpackage : sdc_pkg

// ==== logic/sdc_serial_shift.sv ====
`timescale 1ns/100ps
module sdc_serial_shift #(
  parameter int WORD_W = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Three-wire serial pins.
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load,
  // Assembled word.
  output sdc_pkg::sdc_word_t word_out
);
  import sdc_pkg::*;

  // Only a full 32-bit word maps onto the register layout.
  if (WORD_W != 32) begin : g_width_chk
    $error("sdc_serial_shift supports only WORD_W of 32");
  end

  typedef enum logic [1:0] {
    SDC_SH_SHIFT = 2'b00,
    SDC_SH_LOAD = 2'b01,
    SDC_SH_WAIT = 2'b10
  } sdc_sh_st_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] prev;
    logic [31:0] shreg;
    sdc_sh_st_t fsm;
    sdc_word_t out;
  } sdc_shift_t;

  sdc_shift_t st_r;
  sdc_shift_t st_nxt;
  logic clk_rise;
  logic load_rise;

  // Edges are found only on the second synchroniser stage.
  assign clk_rise = st_r.s2[0] & ~st_r.prev[0];
  assign load_rise = st_r.s2[2] & ~st_r.prev[2];

  // Shift MSB first on each serial clock rise; hand the word over on the load rise.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {ser_load, ser_data, ser_clk};
    st_nxt.s2 = st_r.s1;
    st_nxt.prev = st_r.s2;
    st_nxt.out.valid = 1'b0;
    if (clk_rise) begin
      st_nxt.shreg = {st_r.shreg[30:0], st_r.s2[1]};
    end
    case (st_r.fsm)
      SDC_SH_SHIFT: begin
        if (load_rise) begin
          st_nxt.fsm = SDC_SH_LOAD;
        end
      end
      SDC_SH_LOAD: begin
        st_nxt.out.valid = 1'b1;
        st_nxt.out.data = st_r.shreg;
        st_nxt.fsm = SDC_SH_WAIT;
      end
      SDC_SH_WAIT: begin
        // A load held high hands over one word only.
        if (!st_r.s2[2]) begin
          st_nxt.fsm = SDC_SH_SHIFT;
        end
      end
      default: begin
        st_nxt.fsm = SDC_SH_SHIFT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word_out = st_r.out;

  load_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_rise && st_r.fsm == SDC_SH_SHIFT |-> ##2 word_out.valid ##1 !word_out.valid)
    else $error("load edge did not give one word pulse");
endmodule : sdc_serial_shift

// ==== logic/sdc_config_regs.sv ====
`timescale 1ns/100ps
module sdc_config_regs (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Three-wire serial pins.
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load,
  // Reference pin.
  input wire logic reference_input,
  // Active configuration.
  output sdc_pkg::sdc_div_t div_cfg,
  output sdc_pkg::sdc_r1_t r1_cfg,
  output sdc_pkg::sdc_r2_t r2_cfg,
  output sdc_pkg::sdc_r3_t r3_cfg,
  // Derived controls.
  output logic dither_en,
  output logic low_noise_en,
  output logic ref_both_edges,
  output logic pfd_ref_pulse,
  output logic monitor_pin,
  // Range flags, updated when register 0 is written.
  output logic int_range_err,
  output logic numerator_range_err,
  output logic phase_range_err
);
  import sdc_pkg::*;

  typedef struct packed {
    logic [2:0] ref_sync;
    sdc_div_t div;
    sdc_r1_t r1_act;
    logic [11:0] phase_sh;
    logic [11:0] den_sh;
    sdc_r2_t r2_act;
    logic dbl_sh;
    sdc_r3_t r3;
    logic dither_en;
    logic low_noise_en;
    logic ref_both_edges;
    logic pfd_ref_pulse;
    logic monitor_pin;
    logic word_loaded;
    logic int_err;
    logic num_err;
    logic phase_err;
  } sdc_main_st_t;

  sdc_main_st_t st_r;
  sdc_main_st_t st_nxt;
  sdc_word_t word;
  logic [2:0] sel;
  logic ref_rise;
  logic ref_fall;

  // True when a value lies at or above the denominator.
  function automatic logic at_or_above(input logic [11:0] val, input logic [11:0] den);
    at_or_above = (val >= den);
  endfunction : at_or_above

  // Least whole divide ratio allowed for a prescaler choice.
  function automatic logic [15:0] int_min(input logic pre);
    int_min = pre ? INT_MIN_P89 : INT_MIN_P45;
  endfunction : int_min

  sdc_serial_shift #(
    .WORD_W(WORD_W)
  ) u_shift (
    .sys_clk(sys_clk),
    .rst(rst),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_load(ser_load),
    .word_out(word)
  );

  assign sel = word.data[SEL_LSB +: SEL_W];
  // The reference passes two stages first; bit 2 holds the previous sample.
  assign ref_rise = st_r.ref_sync[1] & ~st_r.ref_sync[2];
  assign ref_fall = ~st_r.ref_sync[1] & st_r.ref_sync[2];

  // Word routing, shadow transfer and derived controls.
  always_comb begin
    st_nxt = st_r;
    st_nxt.ref_sync = {st_r.ref_sync[1], st_r.ref_sync[0], reference_input};
    st_nxt.word_loaded = word.valid;
    if (word.valid) begin
      case (sel)
        SEL_R0: begin
          st_nxt.div.int_val = word.data[INT_LSB +: INT_W];
          st_nxt.div.channel_numerator = word.data[NUM_LSB +: NUM_W];
          st_nxt.r1_act.phase = st_r.phase_sh;
          st_nxt.r1_act.fraction_denominator = st_r.den_sh;
          st_nxt.r2_act.ref_doubler = st_r.dbl_sh;
          st_nxt.int_err = word.data[INT_LSB +: INT_W] < int_min(st_r.r1_act.prescaler_choice);
          st_nxt.num_err = at_or_above(word.data[NUM_LSB +: NUM_W], st_r.den_sh);
          st_nxt.phase_err = at_or_above(st_r.phase_sh, st_r.den_sh);
        end
        SEL_R1: begin
          st_nxt.r1_act.prescaler_choice = word.data[PRE_BIT];
          st_nxt.den_sh = word.data[DEN_LSB +: DEN_W];
          st_nxt.phase_sh = word.data[PH_LSB +: PH_W];
        end
        SEL_R2: begin
          st_nxt.r2_act.noise_mode = word.data[NOISE_LSB +: NOISE_W];
          st_nxt.r2_act.monitor_pin_select = word.data[MON_LSB +: MON_W];
          st_nxt.dbl_sh = word.data[DBL_BIT];
        end
        SEL_R3: begin
          st_nxt.r3.clkdiv_val = word.data[CDV_LSB +: CDV_W];
          st_nxt.r3.clkdiv_mode = word.data[CDM_LSB +: CDM_W];
          st_nxt.r3.csr_en = word.data[CSR_BIT];
        end
        default: begin
          // Selects 4 to 7 store nothing; the word only sets word_loaded.
          st_nxt.word_loaded = word.valid;
        end
      endcase
    end
    st_nxt.dither_en = (st_r.r2_act.noise_mode == NOISE_LOW_SPUR);
    st_nxt.low_noise_en = (st_r.r2_act.noise_mode == NOISE_LOW_NOISE);
    st_nxt.ref_both_edges = st_r.r2_act.ref_doubler;
    st_nxt.pfd_ref_pulse = ref_fall | (st_r.r2_act.ref_doubler & ref_rise);
    case (st_r.r2_act.monitor_pin_select)
      MON_LOW: st_nxt.monitor_pin = 1'b0;
      MON_HIGH: st_nxt.monitor_pin = 1'b1;
      MON_REF: st_nxt.monitor_pin = st_r.pfd_ref_pulse;
      MON_LOAD: st_nxt.monitor_pin = st_r.word_loaded;
      MON_DITHER: st_nxt.monitor_pin = st_r.dither_en;
      MON_ERR: st_nxt.monitor_pin = st_r.int_err | st_r.num_err | st_r.phase_err;
      default: st_nxt.monitor_pin = 1'b0;
    endcase
  end

  // Reset puts a phase word of one and a nonzero denominator in place.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.r1_act.phase <= RST_PHASE;
      st_r.phase_sh <= RST_PHASE;
      st_r.r1_act.fraction_denominator <= RST_DEN;
      st_r.den_sh <= RST_DEN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign div_cfg = st_r.div;
  assign r1_cfg = st_r.r1_act;
  assign r2_cfg = st_r.r2_act;
  assign r3_cfg = st_r.r3;
  assign dither_en = st_r.dither_en;
  assign low_noise_en = st_r.low_noise_en;
  assign ref_both_edges = st_r.ref_both_edges;
  assign pfd_ref_pulse = st_r.pfd_ref_pulse;
  assign monitor_pin = st_r.monitor_pin;
  assign int_range_err = st_r.int_err;
  assign numerator_range_err = st_r.num_err;
  assign phase_range_err = st_r.phase_err;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  reg3_decode_a: assert property (word.valid && sel == SEL_R3 |=>
    r3_cfg.clkdiv_val == $past(word.data[CDV_LSB +: CDV_W]))
    else $error("register 3 word not stored");
  div_store_a: assert property (word.valid && sel == SEL_R0 |=>
    div_cfg.channel_numerator == $past(word.data[NUM_LSB +: NUM_W]))
    else $error("numerator not stored");
  shadow_hold_a: assert property (word.valid && sel == SEL_R1 |=>
    $stable(r1_cfg.fraction_denominator) && $stable(r1_cfg.phase))
    else $error("buffered field applied early");
  den_apply_a: assert property (word.valid && sel == SEL_R0 |=>
    r1_cfg.fraction_denominator == $past(st_r.den_sh))
    else $error("denominator not applied on register 0 write");
  dither_mode_a: assert property (word.valid && sel == SEL_R2 |-> ##2
    dither_en == ($past(word.data[NOISE_LSB +: NOISE_W], 2) == NOISE_LOW_SPUR))
    else $error("dither does not follow mode");
  noise_bits_a: assert property (word.valid && sel == SEL_R2 |=>
    r2_cfg.noise_mode == $past(word.data[NOISE_LSB +: NOISE_W]))
    else $error("noise mode not stored");
  mon_select_a: assert property (word.valid && sel == SEL_R2 |=>
    r2_cfg.monitor_pin_select == $past(word.data[MON_LSB +: MON_W]))
    else $error("monitor select not stored");
  ref_edge_a: assert property (ref_rise && !r2_cfg.ref_doubler |=> !pfd_ref_pulse)
    else $error("rising edge active with doubler off");
  ref_fall_a: assert property (ref_fall |=> pfd_ref_pulse)
    else $error("falling edge not active");
  phase_flag_a: assert property (word.valid && sel == SEL_R0 |=>
    phase_range_err == ($past(st_r.phase_sh) >= $past(st_r.den_sh)))
    else $error("phase range flag wrong");
endmodule : sdc_config_regs

// ==== verification/sdc_host_model.sv ====
`timescale 1ns/100ps
module sdc_host_model (
  // Three-wire serial pins.
  output logic ser_clk,
  output logic ser_data,
  output logic ser_load
);
  event frame_done;

  // The link clock stands low between frames; the strobe parks low and data starts low.
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
  end

  // MSB first, then load
  // Each bit is set while the clock is low and held across its rise.
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      #40 ser_clk = 1'b1;
      #40 ser_clk = 1'b0;
    end
    // The line flips after the frame so a stale bit never passes for valid.
    ser_data = ~w[0];
    #40 ser_load = 1'b1;
    #40 ser_load = 1'b0;
    #40 ->frame_done;
  endtask : send
endmodule : sdc_host_model

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(nm, got, ex) begin \
  checks++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, (ex), (got)); \
  end \
end
module tb_top;
  import sdc_pkg::*;
  typedef struct packed {
    sdc_div_t d;
    sdc_r1_t r1;
    sdc_r2_t r2;
    sdc_r3_t r3;
    logic dith;
    logic lown;
    logic [2:0] err;
  } sdc_snap_t;
  logic sys_clk, rst, ser_clk, ser_data, ser_load, reference_input;
  logic dither_en, low_noise_en, ref_both_edges, pfd_ref_pulse, monitor_pin;
  logic int_range_err, numerator_range_err, phase_range_err;
  sdc_div_t div_cfg;
  sdc_r1_t r1_cfg;
  sdc_r2_t r2_cfg;
  sdc_r3_t r3_cfg;
  sdc_snap_t m, e, q[$];
  logic [11:0] sh_ph, sh_den;
  logic sh_dbl, mk, mx;
  int checks = 0;
  int fail_count = 0;
  int pulses = 0;
  int mon_pulses = 0;
  int p0;
  int m0;

  sdc_config_regs i_sdc_config_regs (.sys_clk(sys_clk), .rst(rst), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_load(ser_load), .reference_input(reference_input),
    .div_cfg(div_cfg), .r1_cfg(r1_cfg), .r2_cfg(r2_cfg), .r3_cfg(r3_cfg),
    .dither_en(dither_en), .low_noise_en(low_noise_en), .ref_both_edges(ref_both_edges),
    .pfd_ref_pulse(pfd_ref_pulse), .monitor_pin(monitor_pin),
    .int_range_err(int_range_err), .numerator_range_err(numerator_range_err),
    .phase_range_err(phase_range_err));
  sdc_host_model i_sdc_host_model (.ser_clk(ser_clk), .ser_data(ser_data),
    .ser_load(ser_load));

  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Counts phase detector pulses and monitor pin pulses; only this process writes them.
  // Sampled on the falling edge, away from the rising edge that launches them.
  always @(negedge sys_clk) begin
    if (pfd_ref_pulse === 1'b1) pulses++;
    if (monitor_pin === 1'b1) mon_pulses++;
  end

  function automatic logic [31:0] w0(input logic [15:0] n, input logic [11:0] f);
    return {1'b0, n, f, SEL_R0};
  endfunction : w0
  function automatic logic [31:0] w1(input logic p, input logic [11:0] ph, d);
    return {4'h0, p, ph, d, SEL_R1};
  endfunction : w1
  function automatic logic [31:0] w2(input logic [1:0] n, input logic [2:0] s, input logic b);
    return {1'b0, n, s, b, 22'($urandom), SEL_R2};
  endfunction : w2

  // Notes the expected state, then ships the word; shadows mirror buffering.
  task automatic put(input logic [31:0] w);
    case (w[2:0])
      SEL_R0: begin
        m.d = {w[30:15], w[14:3]};
        m.r1.phase = sh_ph;
        m.r1.fraction_denominator = sh_den;
        m.r2.ref_doubler = sh_dbl;
        m.err[2] = w[30:15] < (m.r1.prescaler_choice ? INT_MIN_P89 : INT_MIN_P45);
        m.err[1] = w[14:3] >= sh_den;
        m.err[0] = sh_ph >= sh_den;
      end
      SEL_R1: begin
        m.r1.prescaler_choice = w[27];
        sh_ph = w[26:15];
        sh_den = w[14:3];
      end
      SEL_R2: begin
        m.r2.noise_mode = w[30:29];
        m.r2.monitor_pin_select = w[28:26];
        sh_dbl = w[25];
      end
      SEL_R3: m.r3 = {w[18], w[16:15], w[14:3]};
      default: ;
    endcase
    m.dith = m.r2.noise_mode == NOISE_LOW_SPUR;
    m.lown = m.r2.noise_mode == NOISE_LOW_NOISE;
    q.push_back(m);
    @(negedge sys_clk);
    i_sdc_host_model.send(w);
  endtask : put

  // Scoreboard: one note is retired for each frame the host completes.
  initial begin
    forever begin
      @(i_sdc_host_model.frame_done);
      repeat (2) @(negedge sys_clk);
      e = q.pop_front();
      `CHK("div_cfg", div_cfg, e.d)
      `CHK("prescaler", r1_cfg.prescaler_choice, e.r1.prescaler_choice)
      `CHK("phase", r1_cfg.phase, e.r1.phase)
      `CHK("denominator", r1_cfg.fraction_denominator, e.r1.fraction_denominator)
      `CHK("noise_mode", r2_cfg.noise_mode, e.r2.noise_mode)
      `CHK("mon_sel", r2_cfg.monitor_pin_select, e.r2.monitor_pin_select)
      `CHK("doubler", {r2_cfg.ref_doubler, ref_both_edges}, {2{e.r2.ref_doubler}})
      `CHK("r3_cfg", r3_cfg, e.r3)
      `CHK("noise_ctl", {dither_en, low_noise_en}, {e.dith, e.lown})
      `CHK("errors", {int_range_err, numerator_range_err, phase_range_err}, e.err)
      mk = !(e.r2.monitor_pin_select inside {MON_REF, MON_LOAD});
      mx = (e.r2.monitor_pin_select == MON_HIGH) | (|e.err
        & e.r2.monitor_pin_select == MON_ERR) | (e.dith & e.r2.monitor_pin_select == MON_DITHER);
      if (mk) `CHK("monitor_pin", monitor_pin, mx)
    end
  end

  // Counts reference edges that reach the phase detector.
  task automatic ref_run(input logic dbl);
    put(w2(NOISE_LOW_NOISE, MON_REF, dbl));
    put(w0(16'h0100, 12'h000));
    p0 = pulses;
    m0 = mon_pulses;
    repeat (4) begin
      repeat (10) @(negedge sys_clk);
      reference_input = 1'b1;
      repeat (10) @(negedge sys_clk);
      reference_input = 1'b0;
    end
    repeat (10) @(negedge sys_clk);
    `CHK("ref pulses", pulses - p0, dbl ? 8 : 4)
    `CHK("monitor ref pulses", mon_pulses - m0, dbl ? 8 : 4)
  endtask : ref_run

  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // Watchdog at 300 us, well beyond the roughly 125 us the sequence needs.
  initial begin
    #300000;
    fail_count++;
    close_out();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    reference_input = 1'b0;
    m = '0;
    m.r1.phase = RST_PHASE;
    m.r1.fraction_denominator = RST_DEN;
    sh_ph = RST_PHASE;
    sh_den = RST_DEN;
    sh_dbl = 1'b0;
    void'($urandom(32'h1b23));
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    `CHK("r1 reset", r1_cfg, m.r1)
    put({29'($urandom), 3'h5});
    put({29'($urandom), 3'h4});
    put({29'($urandom), SEL_R3});
    put(w2(NOISE_LOW_NOISE, MON_HIGH, 1'b0));
    put(w1(1'b0, 12'h001, 12'h0C8));
    put(w0(16'h0064, 12'h005));
    put(w1(1'b1, 12'h010, 12'h100));
    put(w2(NOISE_LOW_SPUR, MON_DITHER, 1'b1));
    put(w0(16'h004A, 12'h0FF));
    put(w0(INT_MIN_P89, 12'h100));
    put(w1(1'b0, 12'h100, 12'h100));
    put(w2(NOISE_LOW_NOISE, MON_ERR, 1'b0));
    put(w0(16'h0016, 12'h000));
    put(w0(INT_MIN_P45, 12'h000));
    put(w1(1'b0, 12'h001, 12'hFFF));
    put(w0(16'hFFFF, 12'hFFE));
    for (int n = 0; n < 4; n++) begin
      put(w2(2'(n), MON_DITHER, 1'($urandom)));
      put(w0(16'h0100, 12'($urandom % 4095)));
    end
    ref_run(1'b0);
    ref_run(1'b1);
    // Each handed-over word shows one pulse on the monitor pin.
    put(w2(NOISE_LOW_NOISE, MON_LOAD, 1'b0));
    m0 = mon_pulses;
    put({29'($urandom), 3'h4});
    repeat (10) @(negedge sys_clk);
    `CHK("load pulses", mon_pulses - m0, 1)
    repeat (16) put({1'b0, 31'($urandom)});
    repeat (20) @(negedge sys_clk);
    close_out();
  end
endmodule : tb_top
